// file: core/bsram_ctrl.sv
// Purpose: Controller end: issues bursts on the shared address bus
// Assumes: User holds requests until accepted
// Notes:   Writes and reads alternate on rise edges
module bsram_ctrl (
    // Clock and reset
    input  wire logic                                  mclk_in,
    input  wire logic                                  sys_rst_in,
    // Write request: four beats with masks
    input  wire logic                                  wr_valid_in,
    input  wire logic [bsram_pkg::ADDR_W-1:0]          wr_addr_in,
    input  wire logic [3:0][bsram_pkg::DATA_W-1:0]     wr_data_in,
    input  wire logic [3:0][bsram_pkg::MASK_W-1:0]     wr_mask_n_in,
    output logic                                       wr_ready_out,
    // Read request
    input  wire logic                                  rd_valid_in,
    input  wire logic [bsram_pkg::ADDR_W-1:0]          rd_addr_in,
    output logic                                       rd_ready_out,
    // Read data to user
    output logic                                       rd_data_valid_out,
    output logic [bsram_pkg::DATA_W-1:0]               rd_data_out,
    input  wire logic                                  rd_data_ready_in,
    // Memory pins
    bsram_if.ctrl                                      mem_if
);
    typedef struct packed {
        logic                              phase;
        logic [1:0]                        wbeat;
        logic                              wact;
        logic [3:0][bsram_pkg::DATA_W-1:0] wdat;
        logic [3:0][bsram_pkg::MASK_W-1:0] wmsk;
        logic [bsram_pkg::ADDR_W-1:0]      addr;
        logic                              wsel_n;
        logic                              rsel_n;
        logic [bsram_pkg::DATA_W-1:0]      wd;
        logic [bsram_pkg::MASK_W-1:0]      wm;
        logic                              turn;
    } bsram_ctrl_s;
    bsram_ctrl_s st_q, st_d;
    logic rd_buf_ready;

    // Phase 0 is the accept cycle, so the select lands on the positive edge
    assign mem_if.edge_pos            = st_q.phase;
    assign mem_if.edge_neg            = ~st_q.phase;
    assign mem_if.addr                = st_q.addr;
    assign mem_if.write_port_select_n = st_q.wsel_n;
    assign mem_if.read_port_select_n  = st_q.rsel_n;
    assign mem_if.wdata               = st_q.wd;
    assign mem_if.byte_write_mask_n   = st_q.wm;
    // A write burst takes two rise edges, so a new one waits for the last
    assign wr_ready_out = ~st_q.phase && ~st_q.wact && st_q.turn;
    assign rd_ready_out = ~st_q.phase && ~st_q.turn && rd_buf_ready;

    always_comb begin
        st_d       = st_q;
        st_d.phase = ~st_q.phase;
        st_d.wsel_n = 1'b1;
        st_d.rsel_n = 1'b1;
        if (~st_q.phase) begin
            st_d.turn = ~st_q.turn;
            if (wr_valid_in && wr_ready_out) begin
                st_d.wsel_n = 1'b0;
                st_d.addr   = wr_addr_in;
                st_d.wdat   = wr_data_in;
                st_d.wmsk   = wr_mask_n_in;
                st_d.wact   = 1'b1;
                st_d.wbeat  = 2'h0;
            end else if (rd_valid_in && rd_ready_out) begin
                st_d.rsel_n = 1'b0;
                st_d.addr   = rd_addr_in;
            end
        end
        if (st_q.wact || (~st_q.phase && wr_valid_in && wr_ready_out)) begin
            // Data and mask leave together so they land on one edge
            st_d.wd = st_q.wact ? st_q.wdat[st_q.wbeat] : wr_data_in[0];
            st_d.wm = st_q.wact ? st_q.wmsk[st_q.wbeat] : wr_mask_n_in[0];
            if (st_q.wact) begin
                st_d.wbeat = st_q.wbeat + 2'h1;
                st_d.wact  = (st_q.wbeat != 2'h3);
            end else begin
                st_d.wbeat = 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q        <= '0;
            st_q.wsel_n <= 1'b1;
            st_q.rsel_n <= 1'b1;
            st_q.wm     <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    // Buffer absorbs a user stall; reads are only issued with room free
    bsram_skid u_skid (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .s_valid_in  (mem_if.rdata_oe),
        .s_data_in   (mem_if.rdata),
        .s_ready_out (rd_buf_ready),
        .m_valid_out (rd_data_valid_out),
        .m_data_out  (rd_data_out),
        .m_ready_in  (rd_data_ready_in)
    );
endmodule

// file: core/bsram_pkg.sv
// Purpose: Shared constants and types for the burst SRAM port slice
// Assumes: Single 20 MHz clock; each double-rate edge is one enable pulse
// Notes:   Parameters select the x8, x9, x18 or x36 configuration
package bsram_pkg;
    // Configuration widths (x18 by default)
    localparam int DATA_W      = 18;
    localparam int MASK_W      = 2;
    localparam int ADDR_W      = 19;
    localparam int LANE_W      = DATA_W / MASK_W;
    localparam int BURST_LEN   = 4;
    localparam int BEAT_W      = 2;
    // Simulation array depth per sub-array, kept small on purpose
    localparam int SUB_DEPTH_W = 6;
    // Rate divider: a phase toggles every cycle, rise then fall
    localparam int CLK_HZ      = 20_000_000;
    // Delay from read start to first output beat, in half cycles
    localparam int RD_LAT_HALF = 4;
    localparam logic [1:0] RD_CNT_INIT = 2'h0;

    typedef enum logic [1:0] {
        BSRAM_IDLE = 2'b00,
        BSRAM_WAIT = 2'b01,
        BSRAM_DRIVE = 2'b10
    } bsram_rd_e;
endpackage

// file: core/bsram_if.sv
// Purpose: Pin bundle between controller and burst SRAM
// Assumes: All pins are synchronous to one system clock
// Notes:   Read data uses an output enable in place of high impedance
interface bsram_if;
    logic                           edge_pos;
    logic                           edge_neg;
    logic [bsram_pkg::ADDR_W-1:0]   addr;
    logic                           write_port_select_n;
    logic                           read_port_select_n;
    logic [bsram_pkg::DATA_W-1:0]   wdata;
    logic [bsram_pkg::MASK_W-1:0]   byte_write_mask_n;
    logic [bsram_pkg::DATA_W-1:0]   rdata;
    logic                           rdata_oe;

    modport ctrl (
        output edge_pos, edge_neg, addr, write_port_select_n, read_port_select_n,
        output wdata, byte_write_mask_n,
        input  rdata, rdata_oe
    );
    modport mem (
        input  edge_pos, edge_neg, addr, write_port_select_n, read_port_select_n,
        input  wdata, byte_write_mask_n,
        output rdata, rdata_oe
    );
endinterface

// file: core/bsram_skid.sv
// Purpose: Two-entry buffer for read words toward the user
// Assumes: Source cannot stall, so upstream ready is advisory
// Notes:   Holds two words so a one-cycle stall loses none
module bsram_skid (
    // Clock and reset
    input  wire logic                          mclk_in,
    input  wire logic                          sys_rst_in,
    // Upstream
    input  wire logic                          s_valid_in,
    input  wire logic [bsram_pkg::DATA_W-1:0]  s_data_in,
    output logic                               s_ready_out,
    // Downstream
    output logic                               m_valid_out,
    output logic [bsram_pkg::DATA_W-1:0]       m_data_out,
    input  wire logic                          m_ready_in
);
    typedef struct packed {
        logic [1:0]                      cnt;
        logic                            rd;
        logic [1:0][bsram_pkg::DATA_W-1:0] mem;
    } bsram_skid_s;
    bsram_skid_s st_q, st_d;
    logic push;
    logic pop;

    // A full buffer still takes a word when one leaves in the same cycle
    assign s_ready_out = (st_q.cnt != 2'h2) || m_ready_in;
    assign m_valid_out = (st_q.cnt != 2'h0);
    assign m_data_out  = st_q.mem[st_q.rd];

    always_comb begin
        st_d = st_q;
        push = s_valid_in && s_ready_out;
        pop  = m_valid_out && m_ready_in;
        if (push) begin
            // Count two with a pop frees the slot being read out
            st_d.mem[st_q.rd ^ st_q.cnt[0]] = s_data_in;
        end
        if (pop) begin
            st_d.rd = ~st_q.rd;
        end
        st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// file: core/bsram_mem.sv
// Purpose: Memory end: four sub-arrays, masked double-rate writes,
//          double-rate reads with automatic output disable
// Assumes: Controller keeps its side of the pin contract
// Notes:   Array depth is cut down for simulation
//
// Summary of operation
// - x8 nibble masks sampled each write edge
// - Mask zero low nibble, one high
// - Mask captured with its data beat
// - Masked nibble discarded, memory unchanged
// - Byte masks sampled each write edge
// - Masked bytes keep previous contents
// - Mask n covers nine-bit lane n
// - Address sampled on positive rise only
// - Shared address routed to started port
// - Four sub-arrays; address width per variant
// - Address ignored when port deselected
// - Read beats on both clock edges
// - Outputs disabled once read data ends
// - Read width matches configuration
// - Write select low starts a write
// - Read select starts four-beat burst
module bsram_mem (
    // Clock and reset
    input  wire logic   mclk_in,
    input  wire logic   sys_rst_in,
    // Memory pins
    bsram_if.mem        mem_if
);
    localparam int DW = bsram_pkg::DATA_W;
    localparam int LW = bsram_pkg::LANE_W;
    localparam int SW = bsram_pkg::SUB_DEPTH_W;

    typedef struct packed {
        logic          wact;
        logic [1:0]    wbeat;
        logic [SW-1:0] waddr;
        logic [bsram_pkg::RD_LAT_HALF-1:0] rpipe;
        logic [SW-1:0] raddr;
        logic [SW-1:0] rrow;
        logic [1:0]    rbeat;
        logic          oe;
        logic [DW-1:0] q;
    } bsram_mem_s;
    bsram_mem_s st_q, st_d;

    logic                                  any_edge;
    logic                                  wr_start;
    logic                                  rd_start;
    logic                                  wr_en;
    logic [1:0]                            wr_beat;
    logic [SW-1:0]                         wr_row;
    logic                                  rd_fire;
    logic [1:0]                            rd_beat;
    logic [SW-1:0]                         rd_row;
    wire logic [bsram_pkg::MASK_W-1:0][LW-1:0] rd_word;

    assign any_edge      = mem_if.edge_pos || mem_if.edge_neg;
    assign wr_start      = mem_if.edge_pos && !mem_if.write_port_select_n;
    assign rd_start      = mem_if.edge_pos && !mem_if.read_port_select_n;
    assign mem_if.rdata  = st_q.q;
    assign mem_if.rdata_oe = st_q.oe;
    // Beat zero rides with the select, so it bypasses the latched row
    assign wr_en   = any_edge && (wr_start || st_q.wact);
    assign wr_beat = wr_start ? 2'h0 : st_q.wbeat;
    assign wr_row  = wr_start ? mem_if.addr[SW-1:0] : st_q.waddr;
    // Row is copied at burst start so a following read may reuse raddr
    assign rd_fire = any_edge && st_q.rpipe[bsram_pkg::RD_LAT_HALF-1];
    assign rd_beat = rd_fire ? 2'h0 : st_q.rbeat;
    assign rd_row  = rd_fire ? st_q.raddr : st_q.rrow;

    always_comb begin
        st_d = st_q;
        if (wr_start) begin
            st_d.waddr = wr_row;
            st_d.wact  = 1'b1;
            st_d.wbeat = 2'h1;
        end else if (st_q.wact && any_edge) begin
            st_d.wbeat = st_q.wbeat + 2'h1;
            st_d.wact  = (st_q.wbeat != 2'h3);
        end
        if (any_edge) begin
            st_d.rpipe = {st_q.rpipe[bsram_pkg::RD_LAT_HALF-2:0], rd_start};
        end
        if (rd_start) begin
            st_d.raddr = mem_if.addr[SW-1:0];
        end
        st_d.oe = 1'b0;
        if (rd_fire) begin
            st_d.rrow  = st_q.raddr;
            st_d.rbeat = 2'h1;
            st_d.oe    = 1'b1;
            st_d.q     = rd_word;
        end else if (st_q.rbeat != 2'h0 && any_edge) begin
            st_d.rbeat = st_q.rbeat + 2'h1;
            st_d.oe    = 1'b1;
            st_d.q     = rd_word;
        end
    end

    // Beat n of a burst lands in sub-array n under its own lane masks
    genvar g;
    generate
        for (g = 0; g < bsram_pkg::MASK_W; g++) begin : g_lane
            // One lane of all four sub-arrays, so each lane has one writer
            logic [LW-1:0] arr [bsram_pkg::BURST_LEN][2**SW];
            always_ff @(posedge mclk_in) begin
                if (wr_en && !mem_if.byte_write_mask_n[g]) begin
                    arr[wr_beat][wr_row] <=
                        mem_if.wdata[g*LW +: LW];
                end
            end
            assign rd_word[g] = arr[rd_beat][rd_row];
        end
    endgenerate

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// file: tb/bsram_chk.sv
// Purpose: Pin-level checks between controller end and memory end
// Assumes: One clock; reset asynchronous, active high
// Notes:   Sees only the interface signals, never the user ports
module bsram_chk (
    // Clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         sys_rst_in,
    // Memory pins
    input  wire logic                         edge_pos,
    input  wire logic                         edge_neg,
    input  wire logic [bsram_pkg::ADDR_W-1:0] addr,
    input  wire logic                         write_port_select_n,
    input  wire logic                         read_port_select_n,
    input  wire logic [bsram_pkg::DATA_W-1:0] wdata,
    input  wire logic [bsram_pkg::MASK_W-1:0] byte_write_mask_n,
    input  wire logic [bsram_pkg::DATA_W-1:0] rdata,
    input  wire logic                         rdata_oe
);
    // Beats driven so far, modulo one burst
    logic [1:0] beat_q;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) beat_q <= 2'h0;
        else if (rdata_oe) beat_q <= beat_q + 2'h1;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    sequence wr_start; !write_port_select_n; endsequence
    sequence rd_start; !read_port_select_n; endsequence
    sequence burst4; rdata_oe [*4]; endsequence
    phase_alt_a: assert property (edge_pos |=> !edge_pos && edge_neg)
        else $error("edge phases do not alternate");
    wr_on_pos_a: assert property (wr_start |-> edge_pos)
        else $error("write select off the positive edge");
    rd_on_pos_a: assert property (rd_start |-> edge_pos)
        else $error("read select off the positive edge");
    wr_gap_a: assert property (wr_start |=> write_port_select_n [*3])
        else $error("write burst cut short");
    rd_gap_a: assert property (rd_start |=> read_port_select_n [*3])
        else $error("read burst cut short");
    one_port_a: assert property (wr_start |-> read_port_select_n)
        else $error("both ports started on one address");
    rd_lat_a: assert property (rd_start |-> ##[3:6] rdata_oe)
        else $error("read data never driven");
    rd_burst_a: assert property ($rose(rdata_oe) |-> burst4)
        else $error("read burst shorter than four beats");
    oe_off_a: assert property ($fell(rdata_oe) |-> beat_q == 2'h0)
        else $error("outputs released in mid burst");
endmodule

// file: tb/testbench.sv
// Purpose: Joins both ends; writes bursts and reads them back
// Assumes: Array keeps only the low address bits
// Notes:   A one-cycle read stall must lose no word
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [bsram_pkg::DATA_W-1:0]      bsram_w_t;
    typedef logic [3:0][bsram_pkg::DATA_W-1:0] bsram_b_t;
    typedef logic [3:0][bsram_pkg::MASK_W-1:0] bsram_m_t;
    typedef logic [bsram_pkg::ADDR_W-1:0]      bsram_a_t;
    logic     mclk_in, sys_rst_in, wr_valid_in, wr_ready_out, rd_valid_in, rd_ready_out;
    logic     rd_data_valid_out, rd_data_ready_in;
    bsram_a_t wr_addr_in, rd_addr_in;
    bsram_b_t wr_data_in, got, img_a, img_b;
    bsram_m_t wr_mask_n_in;
    bsram_w_t rd_data_out;
    int       n_mismatch, tests_run;
    bsram_if  i_bsram_if ();
    bsram_ctrl i_bsram_ctrl (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .wr_valid_in(wr_valid_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
        .wr_mask_n_in(wr_mask_n_in), .wr_ready_out(wr_ready_out), .rd_valid_in(rd_valid_in),
        .rd_addr_in(rd_addr_in), .rd_ready_out(rd_ready_out),
        .rd_data_valid_out(rd_data_valid_out), .rd_data_out(rd_data_out),
        .rd_data_ready_in(rd_data_ready_in), .mem_if(i_bsram_if));
    bsram_mem i_bsram_mem (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .mem_if(i_bsram_if));
    bsram_chk i_bsram_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .edge_pos(i_bsram_if.edge_pos), .edge_neg(i_bsram_if.edge_neg), .addr(i_bsram_if.addr),
        .write_port_select_n(i_bsram_if.write_port_select_n),
        .read_port_select_n(i_bsram_if.read_port_select_n), .wdata(i_bsram_if.wdata),
        .byte_write_mask_n(i_bsram_if.byte_write_mask_n), .rdata(i_bsram_if.rdata),
        .rdata_oe(i_bsram_if.rdata_oe));
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input bsram_w_t seen, input bsram_w_t exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_up(input string name);
        n_mismatch++;
        $display("mismatch %s expected handshake seen none", name);
        report_and_stop();
    endtask
    // Unmasked lanes take the new word, masked lanes keep the old one
    function automatic bsram_w_t merge(bsram_w_t old, bsram_w_t nw,
                                       logic [bsram_pkg::MASK_W-1:0] m);
        merge = old;
        for (int g = 0; g < bsram_pkg::MASK_W; g++)
            if (m[g] === 1'b0)
                merge[g*bsram_pkg::LANE_W +: bsram_pkg::LANE_W] =
                    nw[g*bsram_pkg::LANE_W +: bsram_pkg::LANE_W];
    endfunction
    task automatic do_write(input bsram_a_t a, input bsram_b_t d, input bsram_m_t m);
        int k;
        @(negedge mclk_in);
        wr_addr_in = a;
        wr_data_in = d;
        wr_mask_n_in = m;
        wr_valid_in = 1'b1;
        for (k = 0; k < 50 && wr_ready_out !== 1'b1; k++) @(negedge mclk_in);
        if (k == 50) give_up("write accept");
        @(negedge mclk_in);
        wr_valid_in = 1'b0;
    endtask
    // Ready is set before sampling, since it decides whether the word leaves
    task automatic do_read(input bsram_a_t a, input bit stall);
        int k;
        int n;
        n = 0;
        @(negedge mclk_in);
        rd_addr_in = a;
        rd_valid_in = 1'b1;
        for (k = 0; k < 50 && rd_ready_out !== 1'b1; k++) @(negedge mclk_in);
        if (k == 50) give_up("read accept");
        for (k = 0; k < 60 && n < 4; k++) begin
            @(negedge mclk_in);
            rd_valid_in = 1'b0;
            rd_data_ready_in = !(stall && n == 1 && rd_data_ready_in);
            if (rd_data_valid_out === 1'b1 && rd_data_ready_in === 1'b1) begin
                got[n] = rd_data_out;
                n++;
            end
        end
        if (n < 4) give_up("read data");
    endtask
    task automatic t_full();
        for (int b = 0; b < 4; b++) begin
            img_a[b] = bsram_w_t'(32'h0001_5A3C + b * 32'h0000_1111);
            img_b[b] = ~img_a[b];
        end
        do_write(bsram_a_t'(8'h05), img_a, '0);
        do_write(bsram_a_t'(8'h2A), img_b, '0);
        do_read(bsram_a_t'(8'h05), 1'b0);
        for (int b = 0; b < 4; b++) check("beat A", got[b], img_a[b]);
        do_read(bsram_a_t'(8'h2A), 1'b0);
        for (int b = 0; b < 4; b++) check("beat B", got[b], img_b[b]);
    endtask
    task automatic t_mask();
        bsram_b_t nd;
        bsram_m_t m;
        for (int b = 0; b < 4; b++) nd[b] = bsram_w_t'(32'h0002_A5F0 - b * 32'h0000_0321);
        m = bsram_m_t'(8'h1B);
        do_write(bsram_a_t'(8'h05), nd, m);
        do_read(bsram_a_t'(8'h05), 1'b1);
        for (int b = 0; b < 4; b++) check("masked", got[b], merge(img_a[b], nd[b], m[b]));
        do_read(bsram_a_t'(8'h2A), 1'b0);
        for (int b = 0; b < 4; b++) check("other addr", got[b], img_b[b]);
    endtask
    initial begin
        sys_rst_in = 1'b1;
        wr_valid_in = 1'b0;
        rd_valid_in = 1'b0;
        rd_data_ready_in = 1'b1;
        wr_addr_in = '0;
        rd_addr_in = '0;
        wr_data_in = '0;
        wr_mask_n_in = '1;
        n_mismatch = 0;
        tests_run = 0;
        repeat (20) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        @(negedge mclk_in);
        t_full();
        t_mask();
        report_and_stop();
    end
endmodule
